//--- design/ciw_pkg.sv
// Constants, register map and period table for the link idle watchdog.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package ciw_pkg;

  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TICK_HZ     = 4_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned MS_PER_S    = 1_000;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_CONFIG  = 8'h28;
  localparam logic [7:0]  IDX_COUNTER = 8'h29;
  localparam logic [7:0]  IDX_CONTROL = 8'h30;
  localparam logic [7:0]  IDX_STATUS  = 8'h31;
  localparam logic [7:0]  IDX_MASK    = 8'h32;

  // Config fields.
  localparam int unsigned PD_LSB      = 4;
  localparam int unsigned FLT_LSB     = 0;
  localparam int unsigned PER_W       = 4;
  localparam int unsigned CNT_W       = 24;
  localparam logic [7:0]  CONFIG_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;

  // Status, mask and control bits.
  localparam int unsigned ST_SILENCE  = 0;
  localparam int unsigned ST_SHUTDOWN = 1;
  localparam int unsigned ST_W        = 2;
  localparam int unsigned CTL_INHIBIT = 0;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Period per code in milliseconds; 0 and reserved codes are disabled.
  localparam int unsigned PERIOD_MS [16] = '{
    0, 100, 500, 1_000, 2_000, 5_000, 10_000, 30_000, 60_000,
    120_000, 300_000, 600_000, 1_800_000, 3_600_000, 0, 0};

  function automatic logic [CNT_W-1:0] period_ticks(
    input logic [PER_W-1:0] code
  );
    int unsigned t;
    t = PERIOD_MS[code] * (TICK_HZ / MS_PER_S);
    return t[CNT_W-1:0];
  endfunction : period_ticks

endpackage : ciw_pkg

//--- design/ciw_top.sv
// Link idle watchdog: idle counter, fault and power-down thresholds, regs.
// Assumes frame_valid and power-off requests come from logic on CLK_I.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module ciw_top #(
  parameter int unsigned TICK_CYCLES = ciw_pkg::TICK_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        FRAME_VALID_I,
  input  wire logic        POWER_OFF_REQ_I,
  output logic             POWER_DOWN_O,
  output logic             IRQ_O,
  input  wire logic [9:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [9:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int unsigned CW = ciw_pkg::CNT_W;
  localparam int unsigned SW = ciw_pkg::ST_W;

  typedef struct packed {
    logic [15:0]   presc;
    logic [CW-1:0] count;
    logic [7:0]    config_v;
    logic          inhibit;
    logic [SW-1:0] status;
    logic [SW-1:0] mask;
    logic          power_down;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } ciw_state_s;

  ciw_state_s st_reg;
  ciw_state_s st_next;
  logic       rst_meta_reg;
  logic       rst_sync_reg;

  // Reset enters asynchronously but is released through two flip-flops.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic          wr_fire;
  logic          rd_fire;
  logic [7:0]    wr_idx;
  logic [7:0]    rd_idx;
  logic          tick;
  logic [CW-1:0] pd_ticks;
  logic [CW-1:0] flt_ticks;
  logic          pd_hit;
  logic          flt_hit;
  logic [SW-1:0] st_set;

  // Write address and data are taken together, one write at a time.
  // Nothing is taken while the internal reset copy is still low, so a
  // request offered too early is simply left waiting instead of lost.
  assign wr_fire       = rst_sync_reg && S_AXI_AWVALID && S_AXI_WVALID
                         && !st_reg.bvalid;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY  = wr_fire;
  assign rd_fire       = rst_sync_reg && S_AXI_ARVALID && !st_reg.rvalid;
  assign S_AXI_ARREADY = rd_fire;
  assign wr_idx        = S_AXI_AWADDR[9:2];
  assign rd_idx        = S_AXI_ARADDR[9:2];

  assign tick = (st_reg.presc == 16'(TICK_CYCLES - 1));

  assign pd_ticks  = ciw_pkg::period_ticks(
    st_reg.config_v[ciw_pkg::PD_LSB +: ciw_pkg::PER_W]);
  assign flt_ticks = ciw_pkg::period_ticks(
    st_reg.config_v[ciw_pkg::FLT_LSB +: ciw_pkg::PER_W]);

  assign pd_hit  = (pd_ticks != ciw_pkg::CNT_RST)
                   && (st_reg.count >= pd_ticks);
  assign flt_hit = (flt_ticks != ciw_pkg::CNT_RST)
                   && (st_reg.count >= flt_ticks);

  always_comb begin
    st_set = '0;
    st_set[ciw_pkg::ST_SILENCE]  = flt_hit;
    st_set[ciw_pkg::ST_SHUTDOWN] = pd_hit || POWER_OFF_REQ_I;
  end

  always_comb begin
    st_next = st_reg;
    st_next.presc = tick ? 16'h0000 : st_reg.presc + 16'h0001;

    if (FRAME_VALID_I && !st_reg.inhibit) begin
      st_next.count = ciw_pkg::CNT_RST;
    end else if (tick && st_reg.count != ciw_pkg::CNT_MAX) begin
      st_next.count = st_reg.count + 24'h000001;
    end

    if (pd_hit || POWER_OFF_REQ_I) begin
      st_next.power_down = 1'b1;
    end

    if (S_AXI_BVALID && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end

    st_next.status = st_reg.status | st_set;
    if (wr_fire) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = ciw_pkg::RESP_OKAY;
      case (wr_idx)
        ciw_pkg::IDX_CONFIG: begin
          if (S_AXI_WSTRB[0]) begin
            st_next.config_v = S_AXI_WDATA[7:0];
          end
        end
        ciw_pkg::IDX_COUNTER: begin
          for (int b = 0; b < 3; b++) begin
            if (S_AXI_WSTRB[b]) begin
              st_next.count[b*8 +: 8] = S_AXI_WDATA[b*8 +: 8];
            end
          end
        end
        ciw_pkg::IDX_CONTROL: begin
          if (S_AXI_WSTRB[0]) begin
            st_next.inhibit = S_AXI_WDATA[ciw_pkg::CTL_INHIBIT];
          end
        end
        ciw_pkg::IDX_STATUS: begin
          // Write one clears, but a new event in the same cycle wins.
          if (S_AXI_WSTRB[0]) begin
            st_next.status = (st_reg.status & ~S_AXI_WDATA[SW-1:0])
                             | st_set;
          end
        end
        ciw_pkg::IDX_MASK: begin
          if (S_AXI_WSTRB[0]) begin
            st_next.mask = S_AXI_WDATA[SW-1:0];
          end
        end
        default: begin
          st_next.bresp = ciw_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = ciw_pkg::RESP_OKAY;
      st_next.rdata  = 32'h00000000;
      case (rd_idx)
        ciw_pkg::IDX_CONFIG: begin
          st_next.rdata[7:0] = st_reg.config_v;
        end
        ciw_pkg::IDX_COUNTER: begin
          st_next.rdata[CW-1:0] = st_reg.count;
        end
        ciw_pkg::IDX_CONTROL: begin
          st_next.rdata[ciw_pkg::CTL_INHIBIT] = st_reg.inhibit;
        end
        ciw_pkg::IDX_STATUS: begin
          st_next.rdata[SW-1:0] = st_reg.status;
        end
        ciw_pkg::IDX_MASK: begin
          st_next.rdata[SW-1:0] = st_reg.mask;
        end
        default: begin
          st_next.rresp = ciw_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      st_reg            <= '0;
      st_reg.config_v   <= ciw_pkg::CONFIG_RST;
      st_reg.count      <= ciw_pkg::CNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign POWER_DOWN_O = st_reg.power_down;
  assign IRQ_O        = |(st_reg.status & st_reg.mask);
  assign S_AXI_BVALID = st_reg.bvalid;
  assign S_AXI_BRESP  = st_reg.bresp;
  assign S_AXI_RVALID = st_reg.rvalid;
  assign S_AXI_RRESP  = st_reg.rresp;
  assign S_AXI_RDATA  = st_reg.rdata;

endmodule : ciw_top

//--- test/ciw_monitor.sv
// Checker on the watchdog top ports: power-down and register bus timing.
// Assumes it is bound onto ciw_top and sees nothing beyond its ports.
`timescale 1ns/1ps
module ciw_monitor (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        POWER_OFF_REQ_I,
  input wire logic        POWER_DOWN_O,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  pwr_req_a:
    assert property (POWER_OFF_REQ_I |=> POWER_DOWN_O) else $error("no pd");
  pwr_hold_a:
    assert property (POWER_DOWN_O |=> POWER_DOWN_O) else $error("pd lost");
  wr_take_a:
    assert property (S_AXI_AWREADY == (S_AXI_AWVALID && S_AXI_WVALID
      && !S_AXI_BVALID)) else $error("bad awready");
  wr_pair_a:
    assert property (S_AXI_WREADY == S_AXI_AWREADY)
      else $error("wready differs from awready");
  wr_resp_a:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY ##1 1'b1 |-> S_AXI_BVALID)
      else $error("no bvalid");
  b_hold_a:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
      && $stable(S_AXI_BRESP)) else $error("b dropped");
  rd_take_a:
    assert property (S_AXI_ARREADY == (S_AXI_ARVALID && !S_AXI_RVALID))
      else $error("bad arready");
  rd_resp_a:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no rvalid");
  r_hold_a:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
      && $stable(S_AXI_RDATA)) else $error("r dropped");
  wr_c: cover property (S_AXI_BVALID && S_AXI_BREADY);
  rd_c: cover property (S_AXI_RVALID && S_AXI_RREADY);
  pd_c: cover property ($rose(POWER_DOWN_O));
endmodule : ciw_monitor

bind ciw_top ciw_monitor i_mon (.*);

//--- test/ciw_host_model.sv
// Host side model: sends one-cycle valid-frame pulses on request.
// Assumes requests on the same clock; GAP sets how slowly it answers.
`timescale 1ns/1ps
module ciw_host_model #(
  parameter int GAP = 0
) (
  input  wire logic clk_i,
  input  wire logic send_i,
  output logic      frame_o = 1'b0
);
  int cnt = -1;
  always_ff @(posedge clk_i) begin
    frame_o <= (cnt == 0);
    cnt     <= send_i ? GAP : (cnt >= 0 ? cnt - 1 : -1);
  end
endmodule : ciw_host_model

//--- test/tb.sv
// Self-checking bench for the link idle watchdog.
// Assumes ciw_pkg, ciw_top, the host model and the monitor are compiled.
`timescale 1ns/1ps
module tb;
  logic CLK_I, RST_N_I, POWER_OFF_REQ_I, POWER_DOWN_O, IRQ_O, send;
  logic FRAME_VALID_I, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [9:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [7:0] c;
  int unsigned t;
  int mismatches = 0;
  int cmp_count = 0;
  // Rows hold the config byte, then the expected silence fault bit.
  logic [8:0] rows [7] = '{9'h003, 9'h00B, 9'h000, 9'h01C, 9'h01E,
                           9'h1C0, 9'h01B};

  ciw_top #(.TICK_CYCLES(4)) i_dut (.*);
  ciw_host_model #(.GAP(2)) i_host (.clk_i(CLK_I), .send_i(send),
                                    .frame_o(FRAME_VALID_I));

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic hang(inout int n);
    if (++n > 99) begin
      chk("bus wait", 32'h1, 32'h0);
      final_report();
    end
  endtask : hang

  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    int n = 0;
    S_AXI_AWADDR  <= {i, 2'b00};
    S_AXI_WDATA   <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    do begin @(negedge CLK_I); hang(n); end while (S_AXI_AWREADY !== 1'b1);
    @(posedge CLK_I);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID  <= 1'b0;
    do begin @(negedge CLK_I); hang(n); end while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    @(posedge CLK_I);
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK_I);
  endtask : wr

  task automatic rd(input logic [7:0] i);
    int n = 0;
    S_AXI_ARADDR  <= {i, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do begin @(negedge CLK_I); hang(n); end while (S_AXI_ARREADY !== 1'b1);
    @(posedge CLK_I);
    S_AXI_ARVALID <= 1'b0;
    do begin @(negedge CLK_I); hang(n); end while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    @(posedge CLK_I);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK_I);
  endtask : rd

  task automatic frame;
    send <= 1'b1;
    @(posedge CLK_I);
    send <= 1'b0;
    repeat (4) @(posedge CLK_I);
  endtask : frame

  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  initial begin
    {RST_N_I, POWER_OFF_REQ_I, send, S_AXI_AWVALID, S_AXI_WVALID} = '0;
    {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (20) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    wr(8'h32, 32'h1);
    foreach (rows[k]) begin
      c = rows[k][8:1];
      t = ciw_pkg::PERIOD_MS[c[3:0]] * 4;
      wr(8'h29, 32'h0);
      wr(8'h31, 32'h3);
      wr(8'h28, {24'h0, c});
      wr(8'h29, t != 0 ? t - 1 : 32'hFFFFF0);
      repeat (20) @(posedge CLK_I);
      rd(8'h31);
      chk("fault", {31'h0, rows[k][0]}, d);
      chk("irq", {31'h0, rows[k][0]}, {31'h0, IRQ_O});
      chk("pd", 32'h0, {31'h0, POWER_DOWN_O});
    end
    wr(8'h32, 32'h0);
    chk("masked irq", 32'h0, {31'h0, IRQ_O});
    wr(8'h29, 32'h0);
    wr(8'h31, 32'h1);
    rd(8'h31);
    chk("cleared", 32'h0, d);
    rd(8'h28);
    chk("config", 32'h0D, d);
    rd(8'h10);
    chk("unmapped rd", 32'h2, {30'h0, r} | d);
    wr(8'h10, 32'h1);
    chk("unmapped wr", 32'h2, {30'h0, r});
    wr(8'h30, 32'h1);
    wr(8'h29, 32'hFF000123);
    frame();
    repeat (36) @(posedge CLK_I);
    rd(8'h29);
    chk("live count", 32'h1, {31'h0, d > 32'h12B && d < 32'h131});
    wr(8'h30, 32'h0);
    wr(8'h29, 32'h123);
    frame();
    rd(8'h29);
    chk("frame clear", 32'h1, {31'h0, d < 32'h4});
    // Fault period shorter than power-down, so the fault comes first.
    wr(8'h28, 32'h21);
    wr(8'h29, 32'h18E);
    repeat (20) @(posedge CLK_I);
    chk("fault first", 32'h0, {31'h0, POWER_DOWN_O});
    wr(8'h29, 32'h7CE);
    repeat (20) @(posedge CLK_I);
    chk("idle pd", 32'h1, {31'h0, POWER_DOWN_O});
    rd(8'h31);
    chk("pd status", 32'h3, d);
    RST_N_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk("reset pd", 32'h0, {31'h0, POWER_DOWN_O});
    rd(8'h28);
    chk("reset cfg", 32'h0, d);
    POWER_OFF_REQ_I <= 1'b1;
    @(posedge CLK_I);
    POWER_OFF_REQ_I <= 1'b0;
    rd(8'h31);
    chk("request pd", 32'h2, d | {31'h0, ~POWER_DOWN_O});
    final_report();
  end
endmodule : tb
